//--- shared/jtl_map.vh
// jtl_map.vh: opcodes, field positions, reset values and link offsets for the jump/link unit
// assumes: included by bare name from every design file of the unit
`ifndef JTL_MAP_VH
`define JTL_MAP_VH

// ============================================================
// major opcodes
// ============================================================
`define JTL_OP_REGION_CALL_SHORT_SLOT      6'h1D
`define JTL_OP_CALL_AND_SWITCH_ENCODING      6'h3C
`define JTL_OP_GRPC      6'h11
`define JTL_OP_LBU       6'h02

// ============================================================
// minor codes of the short group c
// ============================================================
`define JTL_MIN_REG_JUMP_SHORT     5'h0C
`define JTL_MIN_JRC      5'h0D
`define JTL_MIN_JRSP     5'h18

// ============================================================
// field positions
// ============================================================
`define JTL_F32_MAJ      31:26
`define JTL_F32_INDEX    25:0
`define JTL_F16_MAJ      15:10
`define JTL_F16_MINOR    9:5
`define JTL_F16_IMM      4:0
`define JTL_F16_RT       9:7
`define JTL_F16_OFS      3:0

// ============================================================
// constants and reset values
// ============================================================
`define JTL_OFS_NEG      4'hF
`define JTL_MODE_RST     1'b1
`define JTL_SLOT32       32'h00000004
`define JTL_REGION_CALL_SHORT_SLOT_LINK    32'h00000006
`define JTL_CALL_AND_SWITCH_ENCODING_LINK    32'h00000008
`define JTL_ST_IDLE      2'h0
`define JTL_ST_SLOT      2'h1
`define JTL_ST_LOAD      2'h2

`endif

//--- tb/jtl_checker.sv
// jtl_checker.sv: port-level timing checks for the jump/link unit
// assumes: bound onto jtl_unit from the tb file, one clock, rst async high
`timescale 1ns/10ps

module jtl_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // issue side
  input wire logic        ins_valid,
  input wire logic        ins_is16,
  input wire logic [31:0] ins_word,
  input wire logic [31:0] ins_pc,
  input wire logic [31:0] src_val,
  input wire logic [31:0] ra_val,
  input wire logic [31:0] sp_val,
  input wire logic        full_impl,
  input wire logic [7:0]  mem_rdata,
  // results
  input wire logic        busy,
  input wire logic        pc_load,
  input wire logic [31:0] pc_target,
  input wire logic        mode_flag,
  input wire logic        flush_next,
  input wire logic        resv_err,
  input wire logic        link_we,
  input wire logic [31:0] link_data,
  input wire logic        sp_we,
  input wire logic [31:0] sp_data,
  input wire logic        load_req,
  input wire logic [31:0] load_addr,
  input wire logic        ld_we,
  input wire logic [31:0] ld_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ============================================================
  // decode of the instruction being taken
  // ============================================================
  wire        tk   = ins_valid && !busy;
  wire        g16  = tk && ins_is16 && (ins_word[15:10] == 6'h11);
  wire        jx   = tk && !ins_is16 && (ins_word[31:26] == 6'h3C);
  wire        lb   = tk && ins_is16 && (ins_word[15:10] == 6'h02);
  wire [4:0]  mnr  = ins_word[9:5];
  wire [31:0] pc8  = ins_pc + 32'h00000008;
  wire [31:0] jxl  = {pc8[31:1], mode_flag};
  wire [31:0] imm4 = {25'h0, ins_word[4:0], 2'h0};
  wire [31:0] dofs = (ins_word[3:0] == 4'hF) ? 32'hFFFFFFFF : {28'h0, ins_word[3:0]};

  // ============================================================
  // assertions
  // ============================================================
  property p_flush; flush_next |-> pc_load; endproperty
  a_flush: assert property (p_flush) else $error("flush without pc load");
  property p_mode; !$stable(mode_flag) |-> pc_load; endproperty
  a_mode: assert property (p_mode) else $error("mode moved without pc load");
  property p_jrc; g16 && mnr == 5'h0D |=> pc_load && !busy && pc_target == ($past(src_val) & 32'hFFFFFFFE); endproperty
  a_jrc: assert property (p_jrc) else $error("compact jump wrong");
  property p_jrsp; g16 && mnr == 5'h18 |=> sp_we && flush_next && sp_data == $past(sp_val) + $past(imm4); endproperty
  a_jrsp: assert property (p_jrsp) else $error("stack update wrong");
  property p_ret; g16 && mnr == 5'h18 |=> pc_load && pc_target == ($past(ra_val) & 32'hFFFFFFFE); endproperty
  a_ret: assert property (p_ret) else $error("return target wrong");
  property p_j16; g16 && mnr == 5'h0C |=> busy && !pc_load && !flush_next; endproperty
  a_j16: assert property (p_j16) else $error("short jump skipped slot");
  property p_resv; jx && !full_impl |=> resv_err && !link_we && !busy; endproperty
  a_resv: assert property (p_resv) else $error("no reserved fault");
  property p_link; jx && full_impl |=> link_we && busy && link_data == $past(jxl); endproperty
  a_link: assert property (p_link) else $error("switching link wrong");
  property p_lbu; lb |=> load_req && busy && load_addr == $past(src_val) + $past(dofs); endproperty
  a_lbu: assert property (p_lbu) else $error("load address wrong");
  property p_ld; ld_we |-> !busy && ld_data == {24'h0, $past(mem_rdata)}; endproperty
  a_ld: assert property (p_ld) else $error("load data not zero-extended");
endmodule

//--- tb/tb.sv
// tb.sv: directed scenarios for the jump/link unit
// assumes: jtl_unit and jtl_checker compiled first, 25 MHz clock
`timescale 1ns/10ps

module tb;
  // ============================================================
  // stimulus and observed signals
  // ============================================================
  logic        clk = 1'h0, rst = 1'h1, ins_valid = 1'h0, ins_is16 = 1'h0;
  logic        full_impl = 1'h1, slot_done = 1'h0, mem_rvalid = 1'h0;
  logic [31:0] ins_word = 32'h0, ins_pc = 32'h0, src_val = 32'h0, ra_val = 32'h0, sp_val = 32'h0;
  logic [7:0]  mem_rdata = 8'h0;
  logic        busy, pc_load, mode_flag, flush_next, addr_err, resv_err, link_we, sp_we, load_req, ld_we;
  logic [31:0] pc_target, link_data, sp_data, load_addr, ld_data;
  logic [4:0]  ld_idx;
  int          miscompares = 0, num_checks = 0, cyc = 0;

  jtl_unit dut (.*);

  // clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      test_done;
    end
  end

  // ============================================================
  // shared tasks
  // ============================================================
  task step; @(posedge clk); #1; endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits a bounded time for the unit to answer
  task wait_evt(input bit fin);
    int n;
    n = 0;
    while (n < 4 && (fin ? pc_load | ld_we : pc_load | busy | resv_err) !== 1'h1) begin
      step;
      n++;
    end
    if (n == 4) chk("answer", 1, 0);
  endtask
  task issue(input bit s16, input logic [31:0] w);
    step;
    ins_is16 = s16;
    ins_word = w;
    ins_valid = 1'h1;
    step;
    ins_valid = 1'h0;
    wait_evt(0);
  endtask
  task slot;
    // the retired slot instruction is a plain 32-bit non-jump in every scenario
    slot_done = 1'h1;
    step;
    slot_done = 1'h0;
    wait_evt(1);
  endtask
  task test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ============================================================
  // scenarios
  // ============================================================
  task t_region_call_short_slot;
    ins_pc = 32'h07FFFFFC;
    issue(0, {6'h1D, 26'h1234567});
    chk("region_call_short_slot link", 32'h08000002, link_data);
    slot;
    chk("region_call_short_slot target", {5'h01, 26'h1234567, 1'h0}, pc_target);
    chk("region_call_short_slot mode", 1, mode_flag);
    $display("test region_call_short_slot done");
  endtask
  task t_call_and_switch_encoding;
    ins_pc = 32'h1FFFFFFC;
    issue(0, {6'h3C, 26'h2ABCDEF});
    chk("call_and_switch_encoding link", 32'h20000005, link_data);
    chk("call_and_switch_encoding early mode", 1, mode_flag);
    slot;
    chk("call_and_switch_encoding target", {4'h2, 26'h2ABCDEF, 2'h0}, pc_target);
    chk("call_and_switch_encoding mode", 0, mode_flag);
    full_impl = 1'h0;
    issue(0, {6'h3C, 26'h2ABCDEF});
    chk("call_and_switch_encoding resv", 1, resv_err);
    chk("call_and_switch_encoding resv link", 0, link_we);
    $display("test call_and_switch_encoding done");
  endtask
  task t_rjump;
    logic [4:0]  mn [6] = '{5'h0C, 5'h0C, 5'h0D, 5'h0D, 5'h0C, 5'h0D};
    logic        fl [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
    logic [31:0] sv [6] = '{32'h1003, 32'h2002, 32'h4005, 32'h0008, 32'h3000, 32'h5001};
    logic        em;
    em = 1'h0;
    for (int i = 0; i < 6; i++) begin
      full_impl = fl[i];
      src_val = sv[i];
      issue(1, {16'h0, 6'h11, mn[i], 5'h05});
      if (mn[i] == 5'h0C) begin
        chk("reg_jump_short early", 0, pc_load);
        slot;
      end
      if (fl[i]) em = sv[i][0];
      chk("rj target", sv[i] & 32'hFFFFFFFE, pc_target);
      chk("rj mode", em, mode_flag);
      chk("rj addr err", fl[i] ? !sv[i][0] && sv[i][1] : !sv[i][0], addr_err);
      chk("rj flush", mn[i] == 5'h0D, flush_next);
    end
    $display("test register jumps done");
  endtask
  task t_jrsp;
    full_impl = 1'h1;
    ra_val = 32'h00006007;
    sp_val = 32'hFFFFFFF0;
    issue(1, {16'h0, 6'h11, 5'h18, 5'h1F});
    chk("jrsp sp", 32'h0000006C, sp_data);
    chk("jrsp target", 32'h00006006, pc_target);
    chk("jrsp mode", 1, mode_flag);
    chk("jrsp flush", 1, flush_next);
    $display("test return and pop done");
  endtask
  task t_lbu;
    src_val = 32'h00000100;
    for (int i = 0; i < 2; i++) begin
      issue(1, {16'h0, 6'h02, i ? 3'h3 : 3'h0, 3'h1, i ? 4'hE : 4'hF});
      chk("lbu addr", i ? 32'h0000010E : 32'h000000FF, load_addr);
      mem_rdata = i ? 8'h5A : 8'hA5;
      mem_rvalid = 1'h1;
      step;
      mem_rvalid = 1'h0;
      wait_evt(1);
      chk("lbu data", {24'h0, mem_rdata}, ld_data);
      chk("lbu idx", i ? 32'd3 : 32'd16, {27'h0, ld_idx});
    end
    $display("test byte load done");
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 1'h0;
    t_region_call_short_slot;
    t_call_and_switch_encoding;
    t_rjump;
    t_jrsp;
    t_lbu;
    test_done;
  end
endmodule

bind jtl_unit jtl_checker u_chk (.*);

//--- verilog/jtl_target_calc.v
// jtl_target_calc.v: combinational decode, target, link, stack and address forming
// assumes: operand values are those of the fields of the instruction presented
`timescale 1ns/10ps
`include "jtl_map.vh"

module jtl_target_calc (
  // instruction
  input  wire [31:0] ins_word,
  input  wire        ins_is16,
  input  wire [31:0] ins_pc,
  // operands and state
  input  wire [31:0] src_val,
  input  wire [31:0] ra_val,
  input  wire [31:0] sp_val,
  input  wire        mode,
  input  wire        full_impl,
  // decode
  output wire        dec_region_call_short_slot,
  output wire        dec_call_and_switch_encoding,
  output wire        dec_reg_jump_short,
  output wire        dec_jrc,
  output wire        dec_jrsp,
  output wire        dec_lbu,
  // results
  output reg  [31:0] tgt,
  output reg         tgt_mode,
  output reg         tgt_err,
  output reg  [31:0] link_val,
  output wire [31:0] sp_sum,
  output wire [31:0] ld_addr,
  output wire [4:0]  ld_dst
);

  // encoded byte offset: f means minus one
  function [31:0] ofs_decode;
    input [3:0] code;
    begin
      if (code == `JTL_OFS_NEG)
        ofs_decode = 32'hFFFFFFFF; // RL21
      else
        ofs_decode = {28'h0000000, code}; // RL21
    end
  endfunction

  // 3-bit register field to full register number
  function [4:0] reg_map;
    input [2:0] f;
    begin
      if (f[2:1] == 2'h0)
        reg_map = {4'h8, f[0]};
      else
        reg_map = {2'h0, f};
    end
  endfunction

  wire        grp     = ins_is16 && (ins_word[`JTL_F16_MAJ] == `JTL_OP_GRPC);
  wire [4:0]  minor   = ins_word[`JTL_F16_MINOR];
  wire [31:0] reg_src = dec_jrsp ? ra_val : src_val;
  wire [31:0] slot_pc = ins_pc + `JTL_SLOT32;
  wire [31:0] pc8     = ins_pc + `JTL_CALL_AND_SWITCH_ENCODING_LINK;

  // opcode decode
  assign dec_region_call_short_slot = !ins_is16 && (ins_word[`JTL_F32_MAJ] == `JTL_OP_REGION_CALL_SHORT_SLOT);
  assign dec_call_and_switch_encoding = !ins_is16 && (ins_word[`JTL_F32_MAJ] == `JTL_OP_CALL_AND_SWITCH_ENCODING);
  assign dec_reg_jump_short = grp && (minor == `JTL_MIN_REG_JUMP_SHORT); // RL9
  assign dec_jrc  = grp && (minor == `JTL_MIN_JRC);
  assign dec_jrsp = grp && (minor == `JTL_MIN_JRSP);
  assign dec_lbu  = ins_is16 && (ins_word[`JTL_F16_MAJ] == `JTL_OP_LBU);

  // stack adjust wraps silently, no overflow check
  assign sp_sum  = sp_val + {25'h0000000, ins_word[`JTL_F16_IMM], 2'h0}; // RL16 RL17
  assign ld_addr = src_val + ofs_decode(ins_word[`JTL_F16_OFS]); // RL20
  assign ld_dst  = reg_map(ins_word[`JTL_F16_RT]);

  // target, next mode, fetch fault and link per jump kind
  always @* begin
    tgt      = {reg_src[31:1], 1'b0}; // RL11 RL15
    tgt_mode = full_impl ? reg_src[0] : mode; // RL11 RL15 RL19
    tgt_err  = full_impl ? (!reg_src[0] && reg_src[1]) : !reg_src[0]; // RL12 RL13
    link_val = ins_pc + `JTL_REGION_CALL_SHORT_SLOT_LINK;
    if (dec_region_call_short_slot) begin
      tgt      = {slot_pc[31:27], ins_word[`JTL_F32_INDEX], 1'b0}; // RL1
      tgt_mode = mode;
      tgt_err  = 1'b0;
    end else if (dec_call_and_switch_encoding) begin
      tgt      = {slot_pc[31:28], ins_word[`JTL_F32_INDEX], 2'h0}; // RL4 RL5
      tgt_mode = ~mode; // RL6
      tgt_err  = 1'b0;
      link_val = {pc8[31:1], mode}; // RL3
    end
  end

endmodule

//--- verilog/jtl_unit.v
// jtl_unit.v: jump, link and short byte load execution for the compressed encoding
// assumes: fetch/decode presents one instruction with its operands; pipeline reports
// retirement of a delay-slot instruction on slot_done; memory answers loads on mem_rvalid
//
// Contract
// RL1 - short-slot call keeps upper target bits from pc; last word reaches next region
// RL2 - software keeps branches, jumps, returns and wait out of delay slots
// RL3 - switching call links pc plus 8 into r31, bit 0 carries mode flag
// RL4 - switching call low 26 target bits are target field shifted left two; code fills the low 28 bits with it
// RL5 - switching call upper bits come from following instruction address
// RL6 - switching call inverts mode flag at target, after its delay slot
// RL7 - software puts a 32-bit instruction in the switching call slot
// RL8 - switching call without full-width set raises reserved-instruction fault
// RL9 - short register jump decodes as group 010001, minor 01100, rs field
// RL10 - short register jump loads pc from rs after its delay slot
// RL11 - register jumps copy rs bit 0 to mode flag, clear target bit 0; code keeps the mode flag when full-width is not set
// RL12 - full-width target with bit 1 set gives fetch address error
// RL13 - without full-width set, target bit 0 clear gives fetch address error
// RL14 - software gives register targets legal alignment for selected set
// RL15 - return-and-pop jumps to r31 bit 0 cleared, mode from its bit 0; code keeps the mode flag when full-width is not set
// RL16 - return-and-pop adds immediate times four, zero-extended, into r29
// RL17 - stack pointer update never raises integer overflow
// RL18 - return-and-pop has no delay slot; next instruction is flushed
// RL19 - compact register jump, minor 01101, no slot, mode from bit 0; code keeps the mode flag when full-width is not set
// RL20 - short byte load adds decoded offset to base for address
// RL21 - offset codes 0 to e mean 0 to 14, f means minus one
// RL22 - short byte load zero-extends fetched byte into destination
// RL23 - one mode flag, updated in the same cycle as the pc load
`timescale 1ns/10ps
`include "jtl_map.vh"

module jtl_unit (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // instruction issue
  input  wire        ins_valid,
  input  wire        ins_is16,
  input  wire [31:0] ins_word,
  input  wire [31:0] ins_pc,
  // register operands
  input  wire [31:0] src_val,
  input  wire [31:0] ra_val,
  input  wire [31:0] sp_val,
  // configuration
  input  wire        full_impl,
  // pipeline
  input  wire        slot_done,
  // memory read data
  input  wire        mem_rvalid,
  input  wire [7:0]  mem_rdata,
  // control transfer
  output reg         busy,
  output reg         pc_load,
  output reg  [31:0] pc_target,
  output reg         mode_flag,
  output reg         flush_next,
  output reg         addr_err,
  output reg         resv_err,
  // link write
  output reg         link_we,
  output reg  [31:0] link_data,
  // stack pointer write
  output reg         sp_we,
  output reg  [31:0] sp_data,
  // byte load
  output reg         load_req,
  output reg  [31:0] load_addr,
  output reg         ld_we,
  output reg  [4:0]  ld_idx,
  output reg  [31:0] ld_data
);

  // ============================================================
  // decode and address forming
  // ============================================================

  wire        c_region_call_short_slot;
  wire        c_call_and_switch_encoding;
  wire        c_reg_jump_short;
  wire        c_jrc;
  wire        c_jrsp;
  wire        c_lbu;
  wire [31:0] c_tgt;
  wire        c_mode;
  wire        c_err;
  wire [31:0] c_link;
  wire [31:0] c_sp;
  wire [31:0] c_ld_addr;
  wire [4:0]  c_ld_dst;

  // pure combinational forming of every candidate result
  jtl_target_calc u_calc (
    .ins_word  (ins_word),
    .ins_is16  (ins_is16),
    .ins_pc    (ins_pc),
    .src_val   (src_val),
    .ra_val    (ra_val),
    .sp_val    (sp_val),
    .mode      (mode_flag),
    .full_impl (full_impl),
    .dec_region_call_short_slot  (c_region_call_short_slot),
    .dec_call_and_switch_encoding  (c_call_and_switch_encoding),
    .dec_reg_jump_short  (c_reg_jump_short),
    .dec_jrc   (c_jrc),
    .dec_jrsp  (c_jrsp),
    .dec_lbu   (c_lbu),
    .tgt       (c_tgt),
    .tgt_mode  (c_mode),
    .tgt_err   (c_err),
    .link_val  (c_link),
    .sp_sum    (c_sp),
    .ld_addr   (c_ld_addr),
    .ld_dst    (c_ld_dst)
  );

  // ============================================================
  // sequencing state
  // ============================================================

  reg [1:0]  state;
  reg [31:0] pend_tgt;   // target held across the delay slot
  reg        pend_mode;  // mode flag to apply with the pc load
  reg        pend_err;   // fetch fault to report with the pc load
  reg [4:0]  pend_dst;   // destination of the outstanding load

  // an instruction is only taken while nothing is outstanding
  wire take = ins_valid && (state == `JTL_ST_IDLE);

  // a delayed jump: the short-slot call, the switching call with full-width set, and the short register jump
  wire slot_jump = c_region_call_short_slot || (c_call_and_switch_encoding && full_impl) || c_reg_jump_short;

  // a jump with no delay slot
  wire now_jump = c_jrc || c_jrsp;

  // ============================================================
  // main sequencer
  // ============================================================

  // one clocked process; pulse outputs fall back to zero each cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= `JTL_ST_IDLE;
      busy       <= 1'b0;
      pc_load    <= 1'b0;
      pc_target  <= 32'h00000000;
      mode_flag  <= `JTL_MODE_RST;
      flush_next <= 1'b0;
      addr_err   <= 1'b0;
      resv_err   <= 1'b0;
      link_we    <= 1'b0;
      link_data  <= 32'h00000000;
      sp_we      <= 1'b0;
      sp_data    <= 32'h00000000;
      load_req   <= 1'b0;
      load_addr  <= 32'h00000000;
      ld_we      <= 1'b0;
      ld_idx     <= 5'h00;
      ld_data    <= 32'h00000000;
      pend_tgt   <= 32'h00000000;
      pend_mode  <= `JTL_MODE_RST;
      pend_err   <= 1'b0;
      pend_dst   <= 5'h00;
    end else begin
      pc_load    <= 1'b0;
      flush_next <= 1'b0;
      addr_err   <= 1'b0;
      resv_err   <= 1'b0;
      link_we    <= 1'b0;
      sp_we      <= 1'b0;
      load_req   <= 1'b0;
      ld_we      <= 1'b0;
      case (state)
        `JTL_ST_IDLE: begin
          if (take) begin
            if (c_call_and_switch_encoding && !full_impl) begin
              // no full-width set: fault, no link, no jump
              resv_err <= 1'b1; // RL8
            end else if (slot_jump) begin
              // link now for the two calls, jump once the slot has retired
              link_we   <= c_region_call_short_slot || c_call_and_switch_encoding;
              link_data <= c_link; // RL3
              pend_tgt  <= c_tgt; // RL1 RL4 RL5
              pend_mode <= c_mode;
              pend_err  <= c_err;
              state     <= `JTL_ST_SLOT; // RL6 RL10
              busy      <= 1'b1;
            end else if (now_jump) begin
              // compact jumps take effect at once and drop the next word
              pc_load    <= 1'b1; // RL19
              pc_target  <= c_tgt; // RL15
              mode_flag  <= c_mode; // RL23
              addr_err   <= c_err; // RL12 RL13
              flush_next <= 1'b1; // RL18
              sp_we      <= c_jrsp; // RL16
              sp_data    <= c_sp; // RL17
            end else if (c_lbu) begin
              // start the byte read and wait for its data
              load_req  <= 1'b1;
              load_addr <= c_ld_addr; // RL20
              pend_dst  <= c_ld_dst;
              state     <= `JTL_ST_LOAD;
              busy      <= 1'b1;
            end
          end
        end
        `JTL_ST_SLOT: begin
          // slot instruction retired: redirect and switch mode together
          if (slot_done) begin
            pc_load   <= 1'b1; // RL6 RL10
            pc_target <= pend_tgt;
            mode_flag <= pend_mode; // RL23
            addr_err  <= pend_err; // RL12 RL13
            state     <= `JTL_ST_IDLE;
            busy      <= 1'b0;
          end
        end
        `JTL_ST_LOAD: begin
          // byte returned: zero-extend into destination
          if (mem_rvalid) begin
            ld_we   <= 1'b1;
            ld_idx  <= pend_dst;
            ld_data <= {24'h000000, mem_rdata}; // RL22
            state   <= `JTL_ST_IDLE;
            busy    <= 1'b0;
          end
        end
        default: begin
          state <= `JTL_ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule
